// ==== rtl/wsm_map.svh ====
// Register map, field positions and reset values of the word shift/move unit
// Operation
// - Execution condition off: nothing changes, no word and no flag
// - Arithmetic left shift moves bits up one place, zero into bit 00
// - Arithmetic left shift loads carry with old bit 15
// - Left shift and rotate set zero flag when result word is zero
// - Rotate right: bits down one, old carry to bit 15, bit 00 to carry
// - Indirect pointer not BCD or beyond area boundary sets fault flag
// - Digit shift left moves range up one digit, zero in, top digit lost
// - Range shifts fault on bounds in different areas or first above second
// - Digit shift right moves range down one digit, zero in lower word
// - Long digit shifts may stay partial if power fails midway
// - Word shift moves words toward top, zero lower word, top word lost
// - Copy writes source word or immediate unchanged into target
// - Copy and inverted copy set zero flag when written value is zero
// - Inverted copy writes bitwise complement of source into target
// - Moves change only target words, sources stay as they were
// - Block fill writes source into every word from lower through top
// - Block fill accepts timer/counter words and overwrites present values
// - Block fill faults on bounds in different areas or lower above top
`ifndef WSM_MAP_SVH
`define WSM_MAP_SVH
`define WSM_CTRL_OFS 8'h00
`define WSM_OPA_OFS 8'h04
`define WSM_OPB_OFS 8'h08
`define WSM_SRC_OFS 8'h0c
`define WSM_STAT_OFS 8'h10
`define WSM_MADDR_OFS 8'h14
`define WSM_MDATA_OFS 8'h18
`define WSM_CTRL_OP_LSB 0
`define WSM_CTRL_EXEC_BIT 3
`define WSM_CTRL_IND_A_BIT 4
`define WSM_CTRL_IND_B_BIT 5
`define WSM_CTRL_IND_S_BIT 6
`define WSM_CTRL_IMM_BIT 7
`define WSM_STAT_BUSY_BIT 0
`define WSM_STAT_CARRY_BIT 1
`define WSM_STAT_ZERO_BIT 2
`define WSM_STAT_FAULT_BIT 3
`define WSM_RESP_OKAY 2'b00
`define WSM_RESP_SLVERR 2'b10
`define WSM_CTRL_RST 8'h00
`endif

// ==== rtl/wsm_pkg.sv ====
// Types of the word shift/move unit
package wsm_pkg;
   typedef enum logic [2:0] {
      wsm_arith_shift_left = 3'h0,
      wsm_rotate_right_through_carry = 3'h1,
      wsm_digit_shift_left = 3'h2,
      wsm_digit_shift_right = 3'h3,
      wsm_whole_word_range_shift = 3'h4,
      wsm_copy_word = 3'h5,
      wsm_copy_inverted_word = 3'h6,
      wsm_block_fill = 3'h7
   } wsm_op_t;
   typedef enum logic [1:0] {wsm_idle, wsm_start, wsm_run} wsm_state_t;
endpackage : wsm_pkg

// ==== rtl/wsm_unit.sv ====
// Word shift/move datapath with data memory and AXI4-Lite register slave
`include "wsm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module wsm_unit #(
   parameter int ADDR_W = 8,
   parameter int AREA_W = 6,
   parameter int PTR_AREA = 3
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   localparam int MEM_WORDS = 1 << ADDR_W;
   localparam int AREA_WORDS = 1 << AREA_W;
   localparam int AREA_IDX_W = ADDR_W - AREA_W;
   localparam logic [AREA_IDX_W-1:0] PTR_AREA_L = AREA_IDX_W'(PTR_AREA);

   // ------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------
   generate
      if (ADDR_W < 2 || ADDR_W > 12 || AREA_W < 1 || AREA_W >= ADDR_W ||
          PTR_AREA < 0 || PTR_AREA >= (1 << (ADDR_W - AREA_W))) begin : g_bad
         $error("wsm_unit: unsupported parameter values");
      end
   endgenerate

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      wsm_pkg::wsm_state_t state;
      logic [MEM_WORDS-1:0][15:0] mem;
      logic [7:0] ctrl;
      logic [ADDR_W-1:0] opa;
      logic [ADDR_W-1:0] opb;
      logic [15:0] src;
      logic [ADDR_W-1:0] maddr;
      logic carry;
      logic zero;
      logic fault;
      logic [ADDR_W-1:0] lo;
      logic [ADDR_W-1:0] cur;
      logic [15:0] fill;
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic bvalid;
      logic [1:0] bresp;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } wsm_st_t;

   wsm_st_t s_r;
   wsm_st_t s_nxt;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic bcd_ok(input logic [15:0] p);
      bcd_ok = (p[15:12] <= 4'h9) && (p[11:8] <= 4'h9) &&
               (p[7:4] <= 4'h9) && (p[3:0] <= 4'h9);
   endfunction : bcd_ok

   function automatic logic [15:0] bcd_val(input logic [15:0] p);
      bcd_val = 16'(p[15:12]) * 16'd1000 + 16'(p[11:8]) * 16'd100 +
                16'(p[7:4]) * 16'd10 + 16'(p[3:0]);
   endfunction : bcd_val

   // Returns {ok, effective address}
   function automatic logic [ADDR_W:0] resolve(
      input logic [ADDR_W-1:0] a, input logic ind);
      logic [15:0] p;
      logic [15:0] v;
      p = s_r.mem[a];
      v = bcd_val(p);
      if (!ind) begin
         resolve = {1'b1, a};
      end else if (!bcd_ok(p) || v >= 16'(AREA_WORDS)) begin
         resolve = {1'b0, a};
      end else begin
         resolve = {1'b1, PTR_AREA_L, v[AREA_W-1:0]};
      end
   endfunction : resolve

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      merge = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction : merge

   function automatic logic [31:0] status_word(input wsm_st_t st);
      status_word = 32'h0;
      status_word[`WSM_STAT_BUSY_BIT] = (st.state != wsm_pkg::wsm_idle);
      status_word[`WSM_STAT_CARRY_BIT] = st.carry;
      status_word[`WSM_STAT_ZERO_BIT] = st.zero;
      status_word[`WSM_STAT_FAULT_BIT] = st.fault;
   endfunction : status_word

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      logic [31:0] wv;
      logic [ADDR_W:0] ra;
      logic [ADDR_W:0] rb;
      logic [ADDR_W:0] rs;
      logic [15:0] w;
      logic [15:0] bw;
      logic [15:0] res;
      logic [15:0] src_v;
      logic flt;
      logic ranged;
      logic idle;
      wsm_pkg::wsm_op_t op;
      wv = 32'h0;
      ra = '0;
      rb = '0;
      rs = '0;
      w = 16'h0;
      bw = 16'h0;
      res = 16'h0;
      src_v = 16'h0;
      flt = 1'b0;
      ranged = 1'b0;
      s_nxt = s_r;
      op = wsm_pkg::wsm_op_t'(s_r.ctrl[`WSM_CTRL_OP_LSB +: 3]);
      idle = (s_r.state == wsm_pkg::wsm_idle);

      // Write address and data, taken in either order
      if (awvalid && s_r.awready) begin
         s_nxt.awaddr = awaddr;
         s_nxt.aw_held = 1'b1;
         s_nxt.awready = 1'b0;
      end
      if (wvalid && s_r.wready) begin
         s_nxt.wdata = wdata;
         s_nxt.wstrb = wstrb;
         s_nxt.w_held = 1'b1;
         s_nxt.wready = 1'b0;
      end
      if (s_r.aw_held && s_r.w_held && !s_r.bvalid) begin
         s_nxt.aw_held = 1'b0;
         s_nxt.w_held = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = `WSM_RESP_OKAY;
         if (s_r.awaddr == `WSM_CTRL_OFS) begin
            wv = merge({24'h0, s_r.ctrl}, s_r.wdata, s_r.wstrb);
            if (idle) begin
               s_nxt.ctrl = wv[7:0];
               if (wv[`WSM_CTRL_EXEC_BIT]) begin
                  s_nxt.state = wsm_pkg::wsm_start;
               end
            end
         end else if (s_r.awaddr == `WSM_OPA_OFS) begin
            wv = merge(32'(s_r.opa), s_r.wdata, s_r.wstrb);
            if (idle) s_nxt.opa = wv[ADDR_W-1:0];
         end else if (s_r.awaddr == `WSM_OPB_OFS) begin
            wv = merge(32'(s_r.opb), s_r.wdata, s_r.wstrb);
            if (idle) s_nxt.opb = wv[ADDR_W-1:0];
         end else if (s_r.awaddr == `WSM_SRC_OFS) begin
            wv = merge({16'h0, s_r.src}, s_r.wdata, s_r.wstrb);
            if (idle) s_nxt.src = wv[15:0];
         end else if (s_r.awaddr == `WSM_STAT_OFS) begin
            wv = merge(status_word(s_r), s_r.wdata, s_r.wstrb);
            if (idle) s_nxt.carry = wv[`WSM_STAT_CARRY_BIT];
         end else if (s_r.awaddr == `WSM_MADDR_OFS) begin
            wv = merge(32'(s_r.maddr), s_r.wdata, s_r.wstrb);
            s_nxt.maddr = wv[ADDR_W-1:0];
         end else if (s_r.awaddr == `WSM_MDATA_OFS) begin
            wv = merge({16'h0, s_r.mem[s_r.maddr]}, s_r.wdata, s_r.wstrb);
            if (idle) s_nxt.mem[s_r.maddr] = wv[15:0];
         end else begin
            s_nxt.bresp = `WSM_RESP_SLVERR;
         end
      end
      if (s_r.bvalid && bready) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.awready = 1'b1;
         s_nxt.wready = 1'b1;
      end

      // Read channel
      if (arvalid && s_r.arready) begin
         s_nxt.arready = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = `WSM_RESP_OKAY;
         if (araddr == `WSM_CTRL_OFS) begin
            s_nxt.rdata = {24'h0, s_r.ctrl};
         end else if (araddr == `WSM_OPA_OFS) begin
            s_nxt.rdata = 32'(s_r.opa);
         end else if (araddr == `WSM_OPB_OFS) begin
            s_nxt.rdata = 32'(s_r.opb);
         end else if (araddr == `WSM_SRC_OFS) begin
            s_nxt.rdata = {16'h0, s_r.src};
         end else if (araddr == `WSM_STAT_OFS) begin
            s_nxt.rdata = status_word(s_r);
         end else if (araddr == `WSM_MADDR_OFS) begin
            s_nxt.rdata = 32'(s_r.maddr);
         end else if (araddr == `WSM_MDATA_OFS) begin
            s_nxt.rdata = {16'h0, s_r.mem[s_r.maddr]};
         end else begin
            s_nxt.rdata = 32'h0;
            s_nxt.rresp = `WSM_RESP_SLVERR;
         end
      end
      if (s_r.rvalid && rready) begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arready = 1'b1;
      end

      // --------------------------------------------------------
      // Execution engine
      // --------------------------------------------------------
      case (s_r.state)
         wsm_pkg::wsm_start: begin
            ra = resolve(s_r.opa, s_r.ctrl[`WSM_CTRL_IND_A_BIT]);
            rb = resolve(s_r.opb, s_r.ctrl[`WSM_CTRL_IND_B_BIT]);
            rs = resolve(s_r.src[ADDR_W-1:0],
                         s_r.ctrl[`WSM_CTRL_IND_S_BIT]);
            ranged = (op == wsm_pkg::wsm_digit_shift_left) ||
                     (op == wsm_pkg::wsm_digit_shift_right) ||
                     (op == wsm_pkg::wsm_whole_word_range_shift) ||
                     (op == wsm_pkg::wsm_block_fill);
            src_v = s_r.ctrl[`WSM_CTRL_IMM_BIT] ? s_r.src
                    : s_r.mem[rs[ADDR_W-1:0]];
            w = s_r.mem[ra[ADDR_W-1:0]];
            flt = !ra[ADDR_W];
            if (ranged) begin
               if (!rb[ADDR_W] ||
                   ra[ADDR_W-1:AREA_W] != rb[ADDR_W-1:AREA_W] ||
                   ra[ADDR_W-1:0] > rb[ADDR_W-1:0]) begin
                  flt = 1'b1;
               end
            end
            if ((op == wsm_pkg::wsm_copy_word ||
                 op == wsm_pkg::wsm_copy_inverted_word ||
                 op == wsm_pkg::wsm_block_fill) &&
                !s_r.ctrl[`WSM_CTRL_IMM_BIT] && !rs[ADDR_W]) begin
               flt = 1'b1;
            end
            s_nxt.fault = flt;
            s_nxt.state = wsm_pkg::wsm_idle;
            if (!flt) begin
               case (op)
                  wsm_pkg::wsm_arith_shift_left: begin
                     res = {w[14:0], 1'b0};
                     s_nxt.mem[ra[ADDR_W-1:0]] = res;
                     s_nxt.carry = w[15];
                     s_nxt.zero = (res == 16'h0);
                  end
                  wsm_pkg::wsm_rotate_right_through_carry: begin
                     res = {s_r.carry, w[15:1]};
                     s_nxt.mem[ra[ADDR_W-1:0]] = res;
                     s_nxt.carry = w[0];
                     s_nxt.zero = (res == 16'h0);
                  end
                  wsm_pkg::wsm_copy_word: begin
                     s_nxt.mem[ra[ADDR_W-1:0]] = src_v;
                     s_nxt.zero = (src_v == 16'h0);
                  end
                  wsm_pkg::wsm_copy_inverted_word: begin
                     s_nxt.mem[ra[ADDR_W-1:0]] = ~src_v;
                     s_nxt.zero = (src_v == 16'hffff);
                  end
                  default: begin
                     // Range ops walk from top word down, one per cycle
                     s_nxt.lo = ra[ADDR_W-1:0];
                     s_nxt.cur = rb[ADDR_W-1:0];
                     s_nxt.fill = src_v;
                     s_nxt.state = wsm_pkg::wsm_run;
                  end
               endcase
            end
         end
         wsm_pkg::wsm_run: begin
            // Lower neighbour still holds its old value when read
            w = s_r.mem[s_r.cur];
            bw = (s_r.cur == s_r.lo) ? 16'h0
                 : s_r.mem[s_r.cur - 1'b1];
            case (op)
               wsm_pkg::wsm_digit_shift_left:
                  res = {w[11:0], bw[15:12]};
               wsm_pkg::wsm_digit_shift_right:
                  res = {bw[3:0], w[15:4]};
               wsm_pkg::wsm_whole_word_range_shift:
                  res = bw;
               default:
                  res = s_r.fill;
            endcase
            s_nxt.mem[s_r.cur] = res;
            // A reset that cuts a range off midway clears every word to zero
            if (s_r.cur == s_r.lo) begin
               s_nxt.state = wsm_pkg::wsm_idle;
            end else begin
               s_nxt.cur = s_r.cur - 1'b1;
            end
         end
         default: begin
            // Idle: an execution condition off starts nothing
            s_nxt.lo = s_r.lo;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.ctrl <= `WSM_CTRL_RST;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign awready = s_r.awready;
   assign wready = s_r.wready;
   assign bvalid = s_r.bvalid;
   assign bresp = s_r.bresp;
   assign arready = s_r.arready;
   assign rvalid = s_r.rvalid;
   assign rdata = s_r.rdata;
   assign rresp = s_r.rresp;
endmodule : wsm_unit
`default_nettype wire

// ==== verification/wsm_unit_checker.sv ====
// Bus protocol checker of the word shift/move unit
`include "wsm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module wsm_unit_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready
);
   // ----
   // Read address tracker
   // ----
   logic [7:0] ra_r;
   logic ra_ok;
   always_ff @(posedge aclk) begin
      if (arvalid && arready) begin
         ra_r <= araddr;
      end
   end
   assign ra_ok = ra_r <= `WSM_MDATA_OFS && ra_r[1:0] == 2'h0;
   // ----
   // Properties
   // ----
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence wr_answer;
      ##[1:2] bvalid;
   endsequence
   bresp_hold_a: assert property (bvalid && !bready |=>
      bvalid && $stable(bresp))
      else $error("write response dropped early");
   rdata_hold_a: assert property (rvalid && !rready |=>
      rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer changed early");
   wr_answer_a: assert property (wr_taken |-> wr_answer)
      else $error("write response late");
   rd_answer_a: assert property (arvalid && arready |-> ##[1:2] rvalid)
      else $error("read answer late");
   wr_block_a: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   rd_block_a: assert property (rvalid |-> !arready)
      else $error("read taken while answer pending");
   reset_idle_a: assert property ($rose(aresetn) |->
      awready && wready && arready && !bvalid && !rvalid)
      else $error("bus not idle after reset");
   resp_done_a: assert property (bvalid && bready |=> !bvalid)
      else $error("write response repeated");
   rd_map_a: assert property ($rose(rvalid) |-> ra_ok ?
      rresp == `WSM_RESP_OKAY : rresp == `WSM_RESP_SLVERR && rdata == 32'h0)
      else $error("wrong read response code");
endmodule : wsm_unit_checker
bind wsm_unit wsm_unit_checker u_chk (.aclk(aclk), .aresetn(aresetn),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
   .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
   .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
   .rvalid(rvalid), .rready(rready));
`default_nettype wire

// ==== verification/wsm_unit_tb.sv ====
// Self-checking bench of the word shift/move unit
`include "wsm_map.svh"
`timescale 1ns/100ps
`default_nettype none
module wsm_unit_tb;
   localparam logic [1:0] OK = `WSM_RESP_OKAY;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, cy, zf, ft;
   logic [7:0] awaddr, araddr, ra, rb;
   logic [2:0] awprot, arprot;
   logic [3:0] wstrb;
   logic [31:0] wdata, rdata, rv;
   logic [1:0] bresp, rresp, cb, cr;
   logic [15:0] mem [256];
   logic [39:0] tbl [24];
   int fail_count, total_checks, seed;
   wsm_unit u_wsm_unit (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awprot(awprot), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready));
   always #10 aclk = ~aclk;
   // ----
   // Bus tasks
   // ----
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic hs(ref logic rdy);
      int n;
      logic h;
      n = 0;
      do begin
         @(negedge aclk);
         h = rdy;
         rv = rdata;
         cr = rresp;
         cb = bresp;
         @(posedge aclk);
         n++;
      end while (!h && n < 200);
      if (!h) fail_count++;
   endtask : hs
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] e);
      logic pa, pw, ha, hw;
      int n;
      pa = 1'b1;
      pw = 1'b1;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while ((pa || pw) && n < 200) begin
         @(negedge aclk);
         ha = awready;
         hw = wready;
         @(posedge aclk);
         n++;
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         pa = pa && !ha;
         pw = pw && !hw;
      end
      if (pa || pw) fail_count++;
      repeat ($random(seed) & 3) @(posedge aclk);
      bready <= 1'b1;
      hs(bvalid);
      bready <= 1'b0;
      chk(cb, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [1:0] e);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      hs(arready);
      arvalid <= 1'b0;
      repeat ($random(seed) & 1) @(posedge aclk);
      rready <= 1'b1;
      hs(rvalid);
      rready <= 1'b0;
      chk(cr, e);
   endtask : rd
   task automatic poke(input logic [7:0] a, input logic [15:0] d);
      wr(`WSM_MADDR_OFS, {24'h0, a}, OK);
      wr(`WSM_MDATA_OFS, {16'h0, d}, OK);
      mem[a] = d;
   endtask : poke
   // ----
   // Reference model
   // ----
   task automatic ptr(inout logic [7:0] a, inout logic f);
      logic [15:0] p;
      int v;
      p = mem[a];
      v = p[15:12] * 1000 + p[11:8] * 100 + p[7:4] * 10 + p[3:0];
      if (p[15:12] > 9 || p[11:8] > 9 || p[7:4] > 9 || p[3:0] > 9 || v > 63)
         f = 1'b1;
      else
         a = {2'd3, v[5:0]};
   endtask : ptr
   task automatic model(input logic [7:0] c, a, b, input logic [15:0] s);
      logic f;
      logic [7:0] sa;
      logic [15:0] v, w;
      int lo, hi;
      if (!c[3]) return;
      f = 1'b0;
      sa = s[7:0];
      if (c[4]) ptr(a, f);
      if (c[5] && c[2:0] inside {3'd2, 3'd3, 3'd4, 3'd7}) ptr(b, f);
      if (c[6] && !c[7] && c[2:0] inside {3'd5, 3'd6, 3'd7}) ptr(sa, f);
      v = c[7] ? s : mem[sa];
      lo = a;
      hi = b;
      if (c[2:0] inside {3'd2, 3'd3, 3'd4, 3'd7} &&
          (a[7:6] != b[7:6] || a > b))
         f = 1'b1;
      ft = f;
      if (f) return;
      w = mem[a];
      case (c[2:0])
         3'd0: begin
            mem[a] = {w[14:0], 1'b0};
            cy = w[15];
         end
         3'd1: begin
            mem[a] = {cy, w[15:1]};
            cy = w[0];
         end
         3'd5: mem[a] = v;
         3'd6: mem[a] = ~v;
         3'd7: for (int i = lo; i <= hi; i++) mem[i] = v;
         default: for (int i = hi; i >= lo; i--) begin
            w = i > lo ? mem[i-1] : 16'h0;
            if (c[2:0] == 3'd2) mem[i] = {mem[i][11:0], w[15:12]};
            else if (c[2:0] == 3'd3) mem[i] = {w[3:0], mem[i][15:4]};
            else mem[i] = w;
         end
      endcase
      if (c[2:0] inside {3'd0, 3'd1, 3'd5, 3'd6}) zf = mem[a] == 16'h0;
   endtask : model
   task automatic run(input logic [7:0] c, a, b, input logic [15:0] s);
      int n;
      wr(`WSM_OPA_OFS, {24'h0, a}, OK);
      wr(`WSM_OPB_OFS, {24'h0, b}, OK);
      wr(`WSM_SRC_OFS, {16'h0, s}, OK);
      wr(`WSM_CTRL_OFS, {24'h0, c}, OK);
      model(c, a, b, s);
      n = 0;
      do begin
         rd(`WSM_STAT_OFS, OK);
         n++;
      end while (rv[0] !== 1'b0 && n < 300);
      chk(rv, {28'h0, ft, zf, cy, 1'b0});
      for (int i = 0; i < 208; i++) begin
         if (i < 80 || i >= 192) begin
            wr(`WSM_MADDR_OFS, 32'(i), OK);
            rd(`WSM_MDATA_OFS, OK);
            chk(rv, {16'h0, mem[i]});
         end
      end
   endtask : run
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : give_verdict
   // ----
   // Sequence
   // ----
   initial begin
      repeat (60000) @(posedge aclk);
      fail_count++;
      give_verdict();
   end
   initial begin
      aclk = 1'b0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      {awaddr, araddr, wdata, awprot, arprot} = 54'h0;
      wstrb = 4'hf;
      {cy, zf, ft} = 3'h0;
      seed = 74117;
      foreach (mem[i]) mem[i] = 16'h0;
      tbl = '{40'h09_0c_00_0000, 40'h08_0a_00_0000, 40'h08_0b_00_0000,
         40'h08_0e_00_0000, 40'h09_0d_00_0000, 40'h0a_14_17_0000,
         40'h0b_14_17_0000, 40'h0c_14_17_0000, 40'h0a_1e_1e_0000,
         40'h0b_1e_1e_0000, 40'h0f_28_3f_0005, 40'h0a_17_14_0000,
         40'h0c_3c_46_0000, 40'h0f_3f_40_0005, 40'h0b_17_14_0000,
         40'h07_03_09_0000, 40'h8d_08_00_0000, 40'h0d_08_00_0007,
         40'h0e_0f_00_0009, 40'h8e_10_00_ffff, 40'h9d_c8_00_1234,
         40'h4d_02_00_00c8, 40'h9d_c7_00_0001, 40'h9d_c6_00_0001};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`WSM_STAT_OFS, OK);
      chk(rv, 32'h0);
      rd(8'h1c, `WSM_RESP_SLVERR);
      chk(rv, 32'h0);
      wr(8'h1c, 32'h5, `WSM_RESP_SLVERR);
      $display("test bus done");
      for (int i = 0; i < 80; i++) poke(8'(i), 16'($random(seed)));
      poke(8'd200, 16'h0009);
      poke(8'd199, 16'h001a);
      poke(8'd198, 16'h0099);
      poke(8'd10, 16'h8000);
      poke(8'd13, 16'h0001);
      poke(8'd14, 16'h0001);
      wr(`WSM_STAT_OFS, 32'h2, OK);
      cy = 1'b1;
      foreach (tbl[k]) run(tbl[k][39:32], tbl[k][31:24], tbl[k][23:16],
         tbl[k][15:0]);
      $display("test table done");
      for (int k = 0; k < 8; k++) begin
         ra = 8'($random(seed) & 63);
         rb = ra + 8'($random(seed) & 3);
         run(8'h08 | 8'($random(seed) & 7), ra, rb, 16'($random(seed) & 63));
      end
      $display("test random done");
      give_verdict();
   end
endmodule : wsm_unit_tb
`default_nettype wire
